// File: dmr_cfg_sva.sv
// Port checker for the mode configuration block.
// Assumes bind to dmr_mode_cfg; one pclk domain.
`timescale 1ns/1ps
module dmr_cfg_sva
    import dmr_pkg::*;
#(
    parameter int LOCK_CYCLES = DLL_LOCK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Observed inputs
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [ROW_W-1:0] addr,
    input wire logic self_refresh_exit,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // Observed outputs
    input wire logic [2:0] burst_len,
    input wire logic burst_order_bit,
    input wire logic lat_half,
    input wire logic dll_enabled,
    input wire logic dll_reset_pulse,
    input wire logic dll_locked,
    input wire logic col_valid,
    input wire logic [COL_W-1:0] col_addr,
    input wire logic burst_last,
    input wire logic read_data_start
);
    logic [3:0] beat_ff;
    logic [COL_W-1:0] first_ff, msk;
    logic [8:0] en_ff;
    logic [1:0] up_ff;
    logic ld, chg, base;
    // Load decode and block mask
    assign ld = cmd_valid && cmd_code == CMD_LOAD_MODE;
    assign base = {bank_select_high, bank_select_low} == SEL_BASE;
    assign chg = ld || (psel && penable && pwrite);
    assign msk = (10'h1 << burst_len) - 10'h1;
    // Beat index and first column of a burst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beat_ff <= 4'h0;
            first_ff <= '0;
        end else begin
            beat_ff <= (col_valid && !burst_last) ? beat_ff + 4'h1 : 4'h0;
            first_ff <= (col_valid && beat_ff == 4'h0) ? col_addr : first_ff;
        end
    end
    // Cycles with DLL on, cycles since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= 9'h0;
            up_ff <= 2'h0;
        end else begin
            en_ff <= !dll_enabled ? 9'h0 : (en_ff == 9'h1ff ? en_ff : en_ff + 9'h1);
            up_ff <= (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_dll_load;
        ld && base && addr[12:7] == OPMODE_DLL_RESET;
    endsequence
    sequence s_pulse;
        dll_reset_pulse ##1 !dll_reset_pulse;
    endsequence
    AST_DLL_PULSE: assert property (s_dll_load |-> ##[1:2] s_pulse)
        else $error("dll reset pulse missing or long");
    AST_RD_START: assert property (read_data_start |->
        $past(cmd_valid && cmd_code == CMD_READ, 2)) else $error("read start off time");
    AST_BLOCK: assert property (col_valid && beat_ff != 4'h0 |->
        (col_addr >> burst_len) == (first_ff >> burst_len)) else $error("burst left block");
    AST_SEQ: assert property (col_valid && beat_ff != 4'h0 && !burst_order_bit |->
        ((col_addr - first_ff) & msk) == (COL_W'(beat_ff) & msk)) else $error("bad seq order");
    AST_ILV: assert property (col_valid && beat_ff != 4'h0 && burst_order_bit |->
        ((col_addr ^ first_ff) & msk) == (COL_W'(beat_ff) & msk)) else $error("bad ilv order");
    AST_LEN: assert property (col_valid && burst_last |->
        beat_ff == (4'h1 << burst_len) - 4'h1) else $error("burst length wrong");
    AST_HOLD: assert property (up_ff == 2'h3 && !$past(chg) && !$past(chg, 2)
        && !$past(chg, 3) |-> $stable({burst_len, burst_order_bit, lat_half}))
        else $error("mode fields changed without load");
    AST_SR_EXIT: assert property (self_refresh_exit |-> ##[1:2] dll_enabled)
        else $error("dll not on after self refresh exit");
    AST_LAT: assert property (ld && base && addr[6:4] == LAT_TWO_HALF |->
        ##[1:3] lat_half) else $error("half latency not set");
    AST_LOCK: assert property (dll_locked |-> en_ff >= LOCK_CYCLES)
        else $error("dll locked too early");
endmodule : dmr_cfg_sva

bind dmr_mode_cfg dmr_cfg_sva #(.LOCK_CYCLES(LOCK_CYCLES)) dmr_cfg_sva_i (
    .pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr),
    .self_refresh_exit(self_refresh_exit), .psel(psel), .penable(penable), .pwrite(pwrite),
    .burst_len(burst_len), .burst_order_bit(burst_order_bit), .lat_half(lat_half),
    .dll_enabled(dll_enabled), .dll_reset_pulse(dll_reset_pulse), .dll_locked(dll_locked),
    .col_valid(col_valid), .col_addr(col_addr), .burst_last(burst_last),
    .read_data_start(read_data_start)
);

// File: dmr_ctl_model.sv
// Memory controller model issuing mode, read and refresh commands.
// Assumes the bench calls its tasks just after a pclk edge.
`timescale 1ns/1ps
module dmr_ctl_model
    import dmr_pkg::*;
#(
    parameter int LOCK_CYCLES = 8
) (
    // Clock
    input wire logic pclk,
    // Command outputs
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic bank_select_low,
    output logic bank_select_high,
    output logic [ROW_W-1:0] addr,
    output logic self_refresh_exit
);
    int cyc = 0;
    int en_cyc = 0;
    // Idle levels at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_REFRESH;
        {bank_select_high, bank_select_low} = 2'h3;
        addr = '0;
        self_refresh_exit = 1'b0;
    end
    // Free cycle count for the lock wait
    always @(posedge pclk) cyc <= cyc + 1;
    // One command cycle, then released lines change
    task automatic send(input logic [2:0] c, input logic [1:0] bs, input logic [ROW_W-1:0] a);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        {bank_select_high, bank_select_low} <= bs;
        addr <= a;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        addr <= ~a;
    endtask : send
    // Base load: only normal or DLL reset codes are sent
    task automatic ld_base(input logic [ROW_W-1:0] a);
        send(CMD_LOAD_MODE, SEL_BASE, {3'h0, a[9:0] & 10'h17f});
    endtask : ld_base
    // Extended load; a DLL enable restarts the lock wait
    task automatic ld_ext(input logic [ROW_W-1:0] a);
        send(CMD_LOAD_MODE, SEL_EXT, a);
        if (!a[EXT_DLL_DIS_POS]) en_cyc = cyc;
    endtask : ld_ext
    // Read only after the lock wait has run out
    task automatic rd(input logic [COL_W-1:0] col);
        while (cyc - en_cyc < LOCK_CYCLES) @(posedge pclk);
        send(CMD_READ, 2'h0, {3'h0, col});
    endtask : rd
    // Self refresh entry and exit
    task automatic sr();
        send(CMD_REFRESH, 2'h0, '0);
        @(posedge pclk);
        self_refresh_exit <= 1'b1;
        @(posedge pclk);
        self_refresh_exit <= 1'b0;
        en_cyc = cyc;
    endtask : sr
endmodule : dmr_ctl_model

// File: dmr_lat_pipe.sv
// Read latency delay line for the mode register block.
// Assumes single clock domain; depth covers the longest latency.
`timescale 1ns/1ps
module dmr_lat_pipe #(
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Launch and tap
    input wire logic launch,
    input wire logic [1:0] tap,
    output logic hit
);
    logic [DEPTH-1:0] line_ff;

    // Shift register of read launches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_ff <= '0;
        end else begin
            line_ff <= {line_ff[DEPTH-2:0], launch};
        end
    end

    // Registered tap of the selected stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit <= 1'b0;
        end else begin
            hit <= line_ff[tap];
        end
    end
endmodule : dmr_lat_pipe

// File: dmr_mode_cfg.sv
// Mode register, extended mode register, burst column sequencer and DLL lock wait.
// Assumes commands already decoded to a 3-bit code on pclk; APB master on same clock.
`timescale 1ns/1ps
module dmr_mode_cfg
    import dmr_pkg::*;
#(
    parameter int LOCK_CYCLES = DLL_LOCK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Decoded command from the controller
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [ROW_W-1:0] addr,
    input wire logic self_refresh_exit,
    // Configuration outputs
    output logic [2:0] burst_len,
    output logic burst_order_bit,
    output logic lat_half,
    output logic dll_enabled,
    output logic dll_reset_pulse,
    output logic dll_locked,
    // Burst column sequence
    output logic col_valid,
    output logic [COL_W-1:0] col_addr,
    output logic burst_last,
    output logic read_data_start,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Burst length code to beat count minus one; zero when reserved
    function automatic logic [2:0] bl_mask(input logic [2:0] code);
        case (code)
            BL_TWO: bl_mask = 3'h1;
            BL_FOUR: bl_mask = 3'h3;
            BL_EIGHT: bl_mask = 3'h7;
            default: bl_mask = 3'h0;
        endcase
    endfunction : bl_mask

    // Offset of access idx within the block, wrapping on the mask
    function automatic logic [2:0] beat_ofs(input logic [2:0] start, input logic [2:0] idx,
                                            input logic order, input logic [2:0] mask);
        logic [2:0] seq;
        seq = 3'(start + idx);
        beat_ofs = order ? ((start ^ idx) & mask) : (seq & mask); // [R15] [R16] [R17] [R18]
    endfunction : beat_ofs

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic load_base;
    logic load_ext;
    logic is_read;
    logic [5:0] op_mode;
    assign op_mode = addr[ROW_W-1:OPMODE_LSB];
    assign load_base = cmd_valid && cmd_code == CMD_LOAD_MODE
                       && {bank_select_high, bank_select_low} == SEL_BASE; // [R1]
    assign load_ext = cmd_valid && cmd_code == CMD_LOAD_MODE
                      && {bank_select_high, bank_select_low} == SEL_EXT; // [R7]
    assign is_read = cmd_valid && cmd_code == CMD_READ;

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    logic [ROW_W-1:0] mode_ff;
    logic [ROW_W-1:0] ext_ff;
    logic [31:0] apb_wr;
    logic apb_wr_mode;
    logic apb_wr_ext;
    logic mode_bad_ff;
    assign apb_wr = pwdata;
    assign apb_wr_mode = psel && penable && pwrite && paddr == ADDR_MODE;
    assign apb_wr_ext = psel && penable && pwrite && paddr == ADDR_EXT;

    // Base mode register; DLL reset bit never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= MODE_RESET_VAL;
        end else if (load_base) begin
            mode_ff <= addr & ~(ROW_W'(1) << DLL_RESET_POS); // [R3] [R21]
        end else if (apb_wr_mode) begin
            mode_ff <= apb_wr[ROW_W-1:0] & ~(ROW_W'(1) << DLL_RESET_POS);
        end
    end

    // Extended mode register holds until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ff <= EXT_RESET_VAL;
        end else if (load_ext) begin
            ext_ff <= addr; // [R8]
        end else if (apb_wr_ext) begin
            ext_ff <= apb_wr[ROW_W-1:0];
        end
    end

    // One-cycle DLL reset pulse from a valid reset load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_reset_pulse <= 1'b0;
        end else begin
            dll_reset_pulse <= load_base && op_mode == OPMODE_DLL_RESET; // [R4]
        end
    end

    // Sticky flag for reserved operating mode loads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_bad_ff <= 1'b0;
        end else if (load_base && op_mode != OPMODE_NORMAL && op_mode != OPMODE_DLL_RESET) begin
            mode_bad_ff <= 1'b1; // [R6]
        end else if (apb_wr_mode) begin
            mode_bad_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [2:0] lat_code;
    logic lat_ok;
    logic [2:0] mask;
    assign lat_code = mode_ff[LAT_LSB+2:LAT_LSB];
    assign lat_ok = lat_code == LAT_TWO || lat_code == LAT_TWO_HALF; // [R2]
    assign mask = bl_mask(mode_ff[BL_LSB+2:BL_LSB]); // [R19]

    // Registered configuration outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_len <= 3'h0;
            burst_order_bit <= 1'b0;
            lat_half <= 1'b0;
        end else begin
            burst_len <= mode_ff[BL_LSB+2:BL_LSB];
            burst_order_bit <= mode_ff[ORDER_BIT]; // [R20]
            lat_half <= lat_code == LAT_TWO_HALF; // [R2]
        end
    end

    // ------------------------------------------------------------
    // DLL enable and lock wait
    // ------------------------------------------------------------
    logic self_ref_ff;
    logic [LOCK_W-1:0] lock_cnt_ff;
    logic read_early_ff;

    // Self refresh state flag: set by a refresh command, cleared on self refresh exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_ref_ff <= 1'b0;
        end else if (self_refresh_exit) begin
            self_ref_ff <= 1'b0;
        end else if (cmd_valid && cmd_code == CMD_REFRESH) begin
            self_ref_ff <= 1'b1;
        end
    end

    // DLL off from reset; follows the disable bit of each extended write, forced on at self refresh exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_enabled <= 1'b0;
        end else if (self_refresh_exit) begin
            dll_enabled <= 1'b1; // [R13]
        end else if (load_ext || apb_wr_ext) begin
            dll_enabled <= load_ext ? !addr[EXT_DLL_DIS_POS] : !apb_wr[EXT_DLL_DIS_POS]; // [R11]
        end
    end

    // Lock counter restarts on every enable or DLL reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_ff <= '0;
        end else if (self_refresh_exit || dll_reset_pulse
                     || ((load_ext || apb_wr_ext) && !dll_enabled)) begin
            lock_cnt_ff <= '0; // [R12]
        end else if (dll_enabled && lock_cnt_ff != LOCK_W'(LOCK_CYCLES)) begin
            lock_cnt_ff <= lock_cnt_ff + LOCK_W'(1); // [R14]
        end
    end
    assign dll_locked = dll_enabled && lock_cnt_ff == LOCK_W'(LOCK_CYCLES);

    // Sticky flag: read arrived before the lock wait ended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_early_ff <= 1'b0;
        end else if (is_read && !dll_locked) begin
            read_early_ff <= 1'b1; // [R14]
        end else if (psel && penable && pwrite && paddr == ADDR_STATUS) begin
            read_early_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Burst column sequencer
    // ------------------------------------------------------------
    dmr_state_t state_ff;
    logic [2:0] idx_ff;
    logic [2:0] start_ff;
    logic [2:0] mask_ff;
    logic order_ff;
    logic [COL_W-1:0] base_ff;
    logic start_burst;
    assign start_burst = cmd_valid && (cmd_code == CMD_READ || cmd_code[2:1] == 2'h3)
                         && mask != 3'h0;

    // Capture block and start, then step through beats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= DMR_IDLE;
            idx_ff <= 3'h0;
            start_ff <= 3'h0;
            mask_ff <= 3'h0;
            order_ff <= 1'b0;
            base_ff <= '0;
        end else if (start_burst) begin
            state_ff <= DMR_BURST;
            idx_ff <= 3'h0;
            start_ff <= addr[2:0] & mask;
            mask_ff <= mask;
            order_ff <= mode_ff[ORDER_BIT];
            base_ff <= addr[COL_W-1:0] & ~COL_W'(mask); // [R15]
        end else begin
            case (state_ff)
                DMR_IDLE: state_ff <= DMR_IDLE;
                DMR_BURST: begin
                    idx_ff <= idx_ff + 3'h1;
                    if (idx_ff == mask_ff) begin
                        state_ff <= DMR_IDLE;
                    end
                end
                default: state_ff <= DMR_IDLE;
            endcase
        end
    end

    // Registered column output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_valid <= 1'b0;
            col_addr <= '0;
            burst_last <= 1'b0;
        end else begin
            col_valid <= state_ff == DMR_BURST && !start_burst;
            col_addr <= base_ff | COL_W'(beat_ofs(start_ff, idx_ff, order_ff, mask_ff));
            burst_last <= state_ff == DMR_BURST && !start_burst && idx_ff == mask_ff;
        end
    end

    // Read latency: two-stage tap, half clock flagged on lat_half
    dmr_lat_pipe #(
        .DEPTH(4)
    ) u_lat (
        .pclk(pclk),
        .presetn(presetn),
        .launch(is_read && lat_ok),
        .tap(2'h0),
        .hit(read_data_start) // [R22]
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr > ADDR_COUNT;

    // Read data mux registered at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_MODE: prdata <= 32'(mode_ff);
                ADDR_EXT: prdata <= 32'(ext_ff);
                ADDR_STATUS: prdata <= 32'({self_ref_ff, read_early_ff, mode_bad_ff,
                                            !lat_ok, mask == 3'h0, dll_locked, dll_enabled});
                ADDR_BURST: prdata <= 32'({state_ff, idx_ff});
                ADDR_COUNT: prdata <= 32'(lock_cnt_ff);
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule : dmr_mode_cfg

// File: dmr_pkg.sv
// Constants and types for the mode register configuration block.
// Assumes a single pclk domain and an APB master for software access.
// Functional notes
// R1: Controller drives both bank selects low to load the base mode register.
// R2: Latency field 010 means two clocks, 110 means two and a half; others reserved.
// R3: Normal mode is a base load with all operating-mode bits zero.
// R4: DLL reset is a base load with only the DLL reset bit set.
// R5: Controller should follow a DLL reset load with a normal-mode load.
// R6: Controller must not program reserved or test operating modes.
// R7: Extended mode register is loaded with low bank select one, high zero.
// R8: Extended mode contents hold until reprogrammed or power is lost.
// R9: Extended loads only when idle; controller then waits before next command.
// R10: After enabling the DLL the controller issues a DLL reset base load.
// R11: DLL must be enabled for normal operation; disable only for debug.
// R12: Controller enables the DLL at power-up and on return to normal use.
// R13: Leaving self refresh re-enables the DLL without a mode command.
// R14: At least 200 clocks pass after DLL enable before a read.
// R15: Burst column sequence wraps within its aligned block.
// R16: Burst of two: bit 0 gives start, start one gives 1 then 0.
// R17: Burst of four: sequential adds modulo four, interleaved is start XOR index.
// R18: Burst of eight: sequential adds modulo eight, interleaved is start XOR index.
// R19: Low three mode bits: 001 two, 010 four, 011 eight; others reserved.
// R20: Burst order bit zero sequential, one interleaved.
// R21: DLL reset bit clears itself; other mode fields persist.
// R22: Read at edge n with latency m gives first data at edge n plus m.
package dmr_pkg;
    // ------------------------------------------------------------
    // Command encoding and field layout
    // ------------------------------------------------------------
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [1:0] SEL_BASE = 2'h0;
    localparam logic [1:0] SEL_EXT = 2'h1;
    localparam int BL_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int DLL_RESET_POS = 8;
    localparam int OPMODE_LSB = 7;
    localparam int EXT_DLL_DIS_POS = 0;
    localparam logic [2:0] BL_TWO = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] LAT_TWO = 3'h2;
    localparam logic [2:0] LAT_TWO_HALF = 3'h6;
    localparam logic [5:0] OPMODE_NORMAL = 6'h00;
    localparam logic [5:0] OPMODE_DLL_RESET = 6'h02;
    localparam logic [ROW_W-1:0] MODE_RESET_VAL = 13'h0022;
    localparam logic [ROW_W-1:0] EXT_RESET_VAL = 13'h0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int LOCK_W = 8;
    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_EXT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BURST = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam int ST_DLL_ON = 0;
    localparam int ST_LOCKED = 1;
    localparam int ST_BL_BAD = 2;
    localparam int ST_LAT_BAD = 3;
    localparam int ST_MODE_BAD = 4;
    localparam int ST_READ_EARLY = 5;
    localparam int ST_SELF_REF = 6;
    typedef enum logic [1:0] {
        DMR_IDLE = 2'b00,
        DMR_BURST = 2'b01
    } dmr_state_t;
endpackage : dmr_pkg

// File: tb.sv
// Self-checking bench for the mode configuration block.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
module tb;
    import dmr_pkg::*;
    localparam int LK = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ec, cv, ba0, ba1, sre;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [2:0] cc, blen;
    logic [ROW_W-1:0] ad;
    logic [COL_W-1:0] caddr, ex;
    logic bo, lh, den, drp, dlk, colv, blast, rds;
    int err_count = 0;
    int num_checks = 0;
    dmr_ctl_model #(.LOCK_CYCLES(LK)) dmr_ctl_model_i (.pclk(pclk), .cmd_valid(cv),
        .cmd_code(cc), .bank_select_low(ba0), .bank_select_high(ba1), .addr(ad),
        .self_refresh_exit(sre));
    dmr_mode_cfg #(.LOCK_CYCLES(LK)) dmr_mode_cfg_i (.pclk(pclk), .presetn(presetn),
        .cmd_valid(cv), .cmd_code(cc), .bank_select_low(ba0), .bank_select_high(ba1),
        .addr(ad), .self_refresh_exit(sre), .burst_len(blen), .burst_order_bit(bo),
        .lat_half(lh), .dll_enabled(den), .dll_reset_pulse(drp), .dll_locked(dlk),
        .col_valid(colv), .col_addr(caddr), .burst_last(blast), .read_data_start(rds),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // APB transfer; result in rq and ec
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rq = prdata;
        ec = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask : apb
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    // Reset values and unmapped access
    task automatic t_regs();
        apb(1'b0, ADDR_MODE, 32'h0);
        chk("mode reset", rq, {19'h0, MODE_RESET_VAL});
        apb(1'b0, ADDR_EXT, 32'h0);
        chk("ext reset", rq, {19'h0, EXT_RESET_VAL});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", ec, 1);
        chk("unmapped data", rq, 0);
        apb(1'b1, ADDR_STATUS, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("dll off", rq[ST_DLL_ON], 0);
    endtask : t_regs
    // DLL enable, lock wait, DLL reset, ext hold
    task automatic t_dll();
        int n;
        logic saw;
        dmr_ctl_model_i.ld_ext(13'h0002);
        wt(2);
        chk("dll on", den, 1);
        chk("not locked", dlk, 0);
        for (n = 0; n < 40 && dlk !== 1'b1; n++) wt(1);
        chk("locked", dlk, 1);
        chk("lock wait", n + 2 >= LK, 1);
        saw = 1'b0;
        fork
            dmr_ctl_model_i.ld_base(13'h0121);
            repeat (5) @(posedge pclk) saw = saw | drp;
        join
        chk("dll reset pulse", saw, 1);
        apb(1'b0, ADDR_MODE, 32'h0);
        chk("reset bit clear", rq, 32'h021);
        dmr_ctl_model_i.ld_base(13'h0021);
        apb(1'b0, ADDR_EXT, 32'h0);
        chk("ext held", rq, 32'h2);
    endtask : t_dll
    // Every length and order from a start near the top of the column range
    task automatic t_burst();
        logic [COL_W-1:0] st, m;
        for (int l = 1; l < 4; l++) begin
            for (int o = 0; o < 2; o++) begin
                dmr_ctl_model_i.ld_base({6'h0, LAT_TWO, o[0], l[2:0]});
                wt(3);
                chk("len", blen, l);
                chk("order", bo, o);
                st = 10'h3fd;
                m = (10'h1 << l) - 10'h1;
                dmr_ctl_model_i.rd(st);
                wt(1);
                chk("read start", rds, 1);
                for (int i = 0; i < (1 << l); i++) begin
                    if (i > 0) wt(1);
                    ex = (st & ~m) | ((o != 0 ? st ^ i[9:0] : st + i[9:0]) & m);
                    chk("beat", colv, 1);
                    chk("col", caddr, ex);
                    chk("last", blast, i == (1 << l) - 1);
                end
                wt(1);
                chk("end", colv, 0);
            end
        end
        dmr_ctl_model_i.ld_base({6'h0, 3'h3, 4'h0});
        dmr_ctl_model_i.rd(10'h0);
        for (int i = 0; i < 6; i++) begin
            wt(1);
            chk("reserved", colv | rds, 0);
        end
        dmr_ctl_model_i.ld_base({6'h0, LAT_TWO_HALF, 4'h2});
        wt(3);
        chk("half", lh, 1);
    endtask : t_burst
    // DLL disable, then self refresh exit turns it back on
    task automatic t_sr();
        dmr_ctl_model_i.ld_ext(13'h0001);
        wt(3);
        chk("dll disabled", den, 0);
        dmr_ctl_model_i.sr();
        wt(2);
        chk("dll back on", den, 1);
    endtask : t_sr
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_dll();
        t_burst();
        t_sr();
        tally_and_finish();
    end
    // Hang guard
    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end
endmodule : tb
